// *** core/bsc_defines.svh ***
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH

// Register byte offsets
`define BSC_OFF_BUS 12'h018
`define BSC_OFF_IO 12'h01C
`define BSC_OFF_CTRL 12'h040
`define BSC_OFF_IRQ_STAT 12'h044
`define BSC_OFF_IRQ_CLR 12'h048
`define BSC_OFF_IRQ_EN 12'h04C

// Field positions in the bus number word
`define BSC_SEC_BUS_LSB 8
`define BSC_SUB_BUS_LSB 16
`define BSC_LAT_LSB 24

// Field positions in the I/O and status word
`define BSC_IO_BASE_IND_LSB 0
`define BSC_IO_BASE_LSB 4
`define BSC_IO_LIM_IND_LSB 8
`define BSC_IO_LIM_LSB 12
`define BSC_ST_66MHZ 21
`define BSC_ST_FBB 23
`define BSC_ST_PERR 24
`define BSC_ST_DEVSEL_LSB 25
`define BSC_ST_SIG_TABORT 27
`define BSC_ST_RCV_TABORT 28
`define BSC_ST_RCV_MABORT 29
`define BSC_ST_SERR 30
`define BSC_ST_DET_PERR 31

// Control word field
`define BSC_CTRL_PERR_EN 6

// Fixed read values
`define BSC_IO_IND_VAL 4'h1
`define BSC_DEVSEL_VAL 2'h1
`define BSC_66MHZ_VAL 1'b1
`define BSC_FBB_VAL 1'b0

// Reset values
`define BSC_BYTE_RST 8'h00
`define BSC_NIB_RST 4'h0
`define BSC_FLAG_RST 6'h00

// Implied low address bits of the I/O window
`define BSC_IO_BOT_LOW 12'h000
`define BSC_IO_TOP_LOW 12'hFFF

`endif

// *** core/bsc_pkg.sv ***
package bsc_pkg;

  // Latency supervision of unclaimed master cycles
  typedef enum logic [1:0] {
    BSC_LAT_IDLE = 2'b00,
    BSC_LAT_WAIT = 2'b01,
    BSC_LAT_EXPIRE = 2'b11
  } bsc_lat_state_t;

  // Event pulses from the secondary bus logic
  typedef struct packed {
    logic target_abort_sig;
    logic target_abort_rcv;
    logic master_abort_rcv;
    logic parity_detect;
  } bsc_evt_t;

  // Master cycle progress from the secondary bus logic
  typedef struct packed {
    logic start;
    logic claimed;
  } bsc_mst_t;

  // Full 32-bit I/O forwarding window
  typedef struct packed {
    logic [31:0] bottom;
    logic [31:0] top;
  } bsc_win_t;

endpackage : bsc_pkg

// *** core/bsc_regs.sv ***
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "bsc_defines.svh"
module bsc_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic downstream_parity_err_n,
  input wire logic downstream_system_err_n,
  input wire bsc_pkg::bsc_evt_t evt,
  input wire bsc_pkg::bsc_mst_t mst,
  input wire logic [15:0] io_base_upper,
  input wire logic [15:0] io_limit_upper,
  input wire logic io_req,
  input wire logic [31:0] io_addr,
  output logic io_fwd_hit,
  output bsc_pkg::bsc_win_t io_win,
  output logic [7:0] secondary_bus_num_out,
  output logic [7:0] subordinate_bus_num_out,
  output logic unclaimed_timeout,
  output logic irq
);

  logic [7:0] secondary_bus_num;
  logic [7:0] subordinate_bus_num;
  logic [7:0] secondary_latency_count;
  logic [3:0] io_base_nib;
  logic [3:0] io_limit_nib;
  logic perr_en;
  logic [5:0] flags;
  logic [5:0] irq_stat;
  logic [5:0] irq_en;
  logic perr_meta;
  logic perr_sync;
  logic serr_meta;
  logic serr_sync;
  bsc_pkg::bsc_lat_state_t lat_state;
  logic [7:0] lat_cnt;
  logic [5:0] set_vec;
  logic [5:0] w1c_vec;
  logic [5:0] irq_clr_vec;
  logic access;
  logic wr;
  logic [31:0] rd_word;
  logic [31:0] bottom;
  logic [31:0] top;

  // Known register offsets
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `BSC_OFF_BUS) || (a == `BSC_OFF_IO) || (a == `BSC_OFF_CTRL)
      || (a == `BSC_OFF_IRQ_STAT) || (a == `BSC_OFF_IRQ_CLR) || (a == `BSC_OFF_IRQ_EN);
  endfunction : is_mapped

  // Spread the six flags to their status word positions
  function automatic logic [31:0] flags_to_word(input logic [5:0] f);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`BSC_ST_PERR] = f[0];
    w[`BSC_ST_SIG_TABORT] = f[1];
    w[`BSC_ST_RCV_TABORT] = f[2];
    w[`BSC_ST_RCV_MABORT] = f[3];
    w[`BSC_ST_SERR] = f[4];
    w[`BSC_ST_DET_PERR] = f[5];
    flags_to_word = w;
  endfunction : flags_to_word

  // Gather the six flags from their status word positions
  function automatic logic [5:0] word_to_flags(input logic [31:0] w);
    word_to_flags = {w[`BSC_ST_DET_PERR], w[`BSC_ST_SERR], w[`BSC_ST_RCV_MABORT],
      w[`BSC_ST_RCV_TABORT], w[`BSC_ST_SIG_TABORT], w[`BSC_ST_PERR]};
  endfunction : word_to_flags

  // Pin inputs pass two flops before use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      perr_meta <= 1'b1;
      perr_sync <= 1'b1;
      serr_meta <= 1'b1;
      serr_sync <= 1'b1;
    end
    else
    begin
      perr_meta <= downstream_parity_err_n;
      perr_sync <= perr_meta;
      serr_meta <= downstream_system_err_n;
      serr_sync <= serr_meta;
    end
  end

  // APB handshake: one wait state, answer registered
  assign access = psel & penable & pready;
  assign wr = access & pwrite & is_mapped(paddr);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~is_mapped(paddr);
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rd_word;
      else
        prdata <= 32'h0000_0000;
    end
  end

  // Read mux
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (paddr)
      `BSC_OFF_BUS:
      begin
        rd_word[`BSC_SEC_BUS_LSB +: 8] = secondary_bus_num;
        rd_word[`BSC_SUB_BUS_LSB +: 8] = subordinate_bus_num;
        rd_word[`BSC_LAT_LSB +: 8] = secondary_latency_count;
      end
      `BSC_OFF_IO:
      begin
        rd_word = flags_to_word(flags);
        rd_word[`BSC_IO_BASE_IND_LSB +: 4] = `BSC_IO_IND_VAL;
        rd_word[`BSC_IO_LIM_IND_LSB +: 4] = `BSC_IO_IND_VAL;
        rd_word[`BSC_IO_BASE_LSB +: 4] = io_base_nib;
        rd_word[`BSC_IO_LIM_LSB +: 4] = io_limit_nib;
        rd_word[`BSC_ST_66MHZ] = `BSC_66MHZ_VAL;
        rd_word[`BSC_ST_FBB] = `BSC_FBB_VAL;
        rd_word[`BSC_ST_DEVSEL_LSB +: 2] = `BSC_DEVSEL_VAL;
      end
      `BSC_OFF_CTRL:
        rd_word[`BSC_CTRL_PERR_EN] = perr_en;
      `BSC_OFF_IRQ_STAT:
        rd_word[5:0] = irq_stat;
      `BSC_OFF_IRQ_EN:
        rd_word[5:0] = irq_en;
      default:
        rd_word = 32'h0000_0000;
    endcase
  end

  // Bus numbers and latency count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      secondary_bus_num <= `BSC_BYTE_RST;
      subordinate_bus_num <= `BSC_BYTE_RST;
      secondary_latency_count <= `BSC_BYTE_RST;
    end
    else if (wr && paddr == `BSC_OFF_BUS)
    begin
      if (pstrb[1])
        secondary_bus_num <= pwdata[`BSC_SEC_BUS_LSB +: 8];
      if (pstrb[2])
        subordinate_bus_num <= pwdata[`BSC_SUB_BUS_LSB +: 8];
      if (pstrb[3])
        secondary_latency_count <= pwdata[`BSC_LAT_LSB +: 8];
    end
  end

  // Writable I/O window nibbles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_base_nib <= `BSC_NIB_RST;
      io_limit_nib <= `BSC_NIB_RST;
    end
    else if (wr && paddr == `BSC_OFF_IO)
    begin
      if (pstrb[0])
        io_base_nib <= pwdata[`BSC_IO_BASE_LSB +: 4];
      if (pstrb[1])
        io_limit_nib <= pwdata[`BSC_IO_LIM_LSB +: 4];
    end
  end

  // Control and interrupt enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      perr_en <= 1'b0;
      irq_en <= `BSC_FLAG_RST;
    end
    else
    begin
      if (wr && paddr == `BSC_OFF_CTRL && pstrb[0])
        perr_en <= pwdata[`BSC_CTRL_PERR_EN];
      if (wr && paddr == `BSC_OFF_IRQ_EN && pstrb[0])
        irq_en <= pwdata[5:0];
    end
  end

  // Window formed from the nibbles and the upper halves
  assign bottom = {io_base_upper, io_base_nib, `BSC_IO_BOT_LOW};
  assign top = {io_limit_upper, io_limit_nib, `BSC_IO_TOP_LOW};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_win <= '0;
      io_fwd_hit <= 1'b0;
      secondary_bus_num_out <= `BSC_BYTE_RST;
      subordinate_bus_num_out <= `BSC_BYTE_RST;
    end
    else
    begin
      io_win.bottom <= bottom;
      io_win.top <= top;
      io_fwd_hit <= io_req && io_addr >= bottom && io_addr <= top;
      secondary_bus_num_out <= secondary_bus_num;
      subordinate_bus_num_out <= subordinate_bus_num;
    end
  end

  // Unclaimed master cycle supervision
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lat_state <= bsc_pkg::BSC_LAT_IDLE;
      lat_cnt <= `BSC_BYTE_RST;
      unclaimed_timeout <= 1'b0;
    end
    else
    begin
      unclaimed_timeout <= 1'b0;
      case (lat_state)
        bsc_pkg::BSC_LAT_IDLE:
          if (mst.start)
          begin
            lat_cnt <= secondary_latency_count;
            lat_state <= bsc_pkg::BSC_LAT_WAIT;
          end
        bsc_pkg::BSC_LAT_WAIT:
          if (mst.claimed)
            lat_state <= bsc_pkg::BSC_LAT_IDLE;
          else if (lat_cnt == 8'h00)
          begin
            lat_state <= bsc_pkg::BSC_LAT_EXPIRE;
            unclaimed_timeout <= 1'b1;
          end
          else
            lat_cnt <= lat_cnt - 8'h01;
        bsc_pkg::BSC_LAT_EXPIRE:
          lat_state <= bsc_pkg::BSC_LAT_IDLE;
        default:
          lat_state <= bsc_pkg::BSC_LAT_IDLE;
      endcase
    end
  end

  // Flag events; bit order matches flags_to_word
  always_comb
  begin
    set_vec[0] = ~perr_sync & perr_en;
    set_vec[1] = evt.target_abort_sig;
    set_vec[2] = evt.target_abort_rcv;
    set_vec[3] = evt.master_abort_rcv | unclaimed_timeout;
    set_vec[4] = ~serr_sync;
    set_vec[5] = evt.parity_detect;
  end

  assign w1c_vec = (wr && paddr == `BSC_OFF_IO && pstrb[3]) ? word_to_flags(pwdata) : 6'h00;
  assign irq_clr_vec = (wr && paddr == `BSC_OFF_IRQ_CLR && pstrb[0]) ? pwdata[5:0] : 6'h00;

  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags <= `BSC_FLAG_RST;
      irq_stat <= `BSC_FLAG_RST;
    end
    else
    begin
      flags <= (flags & ~w1c_vec) | set_vec;
      irq_stat <= (irq_stat & ~irq_clr_vec) | set_vec;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_en);
  end

endmodule : bsc_regs

// *** bench/bsc_regs_properties.sv ***
`timescale 1ns/1ps
module bsc_regs_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic io_req,
  input wire logic [31:0] io_addr,
  input wire logic io_fwd_hit,
  input wire bsc_pkg::bsc_win_t io_win
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire rd_io = pready && !pslverr && !pwrite && paddr == 12'h01C;
  property p_rdy;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready not a single pulse after one wait");
  property p_ind;
    rd_io |-> prdata[3:0] == 4'h1 && prdata[11:8] == 4'h1;
  endproperty
  a_ind: assert property (p_ind) else $error("io indicator nibbles wrong");
  property p_f66;
    rd_io |-> prdata[21];
  endproperty
  a_f66: assert property (p_f66) else $error("status bit 21 not one");
  property p_fbb;
    rd_io |-> !prdata[23];
  endproperty
  a_fbb: assert property (p_fbb) else $error("status bit 23 not zero");
  property p_dev;
    rd_io |-> prdata[26:25] == 2'b01;
  endproperty
  a_dev: assert property (p_dev) else $error("select timing not medium");
  property p_rsv;
    rd_io |-> prdata[20:16] == 5'h00 && !prdata[22];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved status bits set");
  property p_win;
    $past(presetn) |-> io_win.bottom[11:0] == 12'h000 && io_win.top[11:0] == 12'hFFF;
  endproperty
  a_win: assert property (p_win) else $error("window low bits wrong");
  property p_hit;
    io_req && !pready && !$past(pready) |=>
      io_fwd_hit == ($past(io_addr) >= io_win.bottom && $past(io_addr) <= io_win.top);
  endproperty
  a_hit: assert property (p_hit) else $error("forward decision wrong");
endmodule : bsc_regs_chk

bind bsc_regs bsc_regs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .io_req(io_req), .io_addr(io_addr), .io_fwd_hit(io_fwd_hit), .io_win(io_win));

// *** bench/bsc_host.sv ***
`timescale 1ns/1ps
module bsc_host (
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  initial
  begin
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench watchdog ends a stalled access
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : xfer
endmodule : bsc_host

// *** bench/bsc_regs_tb.sv ***
`timescale 1ns/1ps
module bsc_regs_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, io_fwd_hit, unclaimed_timeout, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic perr_n = 1'b1;
  logic serr_n = 1'b1;
  logic io_req = 1'b0;
  logic [31:0] io_addr = 32'h0;
  logic [15:0] up = 16'h0001;
  logic [15:0] up_t = 16'h0002;
  logic [7:0] sec_out, sub_out;
  bsc_pkg::bsc_evt_t evt = '0;
  bsc_pkg::bsc_mst_t mst = '0;
  bsc_pkg::bsc_win_t io_win;
  int errors = 0;
  int num_checks = 0;
  always #5 pclk = ~pclk;
  bsc_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .downstream_parity_err_n(perr_n), .downstream_system_err_n(serr_n), .evt(evt), .mst(mst),
    .io_base_upper(up), .io_limit_upper(up_t), .io_req(io_req), .io_addr(io_addr), .io_fwd_hit(io_fwd_hit),
    .io_win(io_win), .secondary_bus_num_out(sec_out), .subordinate_bus_num_out(sub_out),
    .unclaimed_timeout(unclaimed_timeout), .irq(irq));
  bsc_host u_host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    num_checks++;
    if (s !== x)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] x);
    u_host.xfer(1'b0, a, 32'h0, 4'hF, rd, e);
    chk(n, x, rd);
  endtask : rd_chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, 4'hF, rd, e);
  endtask : wr
  task automatic flag(input int b);
    rd_chk("flag_set", 12'h01C, 32'h0220_5131 | (32'h1 << b));
    wr(12'h01C, 32'h0000_5030);
    rd_chk("flag_keep", 12'h01C, 32'h0220_5131 | (32'h1 << b));
    wr(12'h01C, 32'h0000_5030 | (32'h1 << b));
    rd_chk("flag_clr", 12'h01C, 32'h0220_5131);
  endtask : flag
  task automatic t_reset;
    rd_chk("bus_rst", 12'h018, 32'h0);
    chk("sec_out_rst", 32'h0, {24'h0, sec_out});
    chk("sub_out_rst", 32'h0, {24'h0, sub_out});
    rd_chk("io_rst", 12'h01C, 32'h0220_0101);
    u_host.xfer(1'b0, 12'h100, 32'h0, 4'hF, rd, e);
    chk("unmapped", 32'h1, {31'h0, e});
  endtask : t_reset
  task automatic t_win;
    logic [31:0] a [4] = '{32'h0001_2FFF, 32'h0001_3000, 32'h0002_5FFF, 32'h0002_6000};
    wr(12'h018, 32'hFFFF_FFFF);
    rd_chk("bus_rw", 12'h018, 32'hFFFF_FF00);
    chk("sec_out", 32'hFF, {24'h0, sec_out});
    chk("sub_out", 32'hFF, {24'h0, sub_out});
    u_host.xfer(1'b1, 12'h018, 32'h0, 4'h4, rd, e);
    rd_chk("bus_strb", 12'h018, 32'hFF00_FF00);
    wr(12'h01C, 32'h00FF_5F3F);
    rd_chk("io_rw", 12'h01C, 32'h0220_5131);
    chk("bottom", 32'h0001_3000, io_win.bottom);
    chk("top", 32'h0002_5FFF, io_win.top);
    foreach (a[i])
    begin
      io_req <= 1'b1;
      io_addr <= a[i];
      @(posedge pclk);
      io_req <= 1'b0;
      @(negedge pclk);
      chk("hit", {31'h0, i == 1 || i == 2}, {31'h0, io_fwd_hit});
      @(posedge pclk);
    end
  endtask : t_win
  task automatic t_evt;
    int b [4] = '{27, 28, 29, 31};
    for (int i = 0; i < 4; i++)
    begin
      evt <= bsc_pkg::bsc_evt_t'(4'h8 >> i);
      @(posedge pclk);
      evt <= '0;
      flag(b[i]);
    end
    perr_n <= 1'b0;
    repeat (5) @(posedge pclk);
    perr_n <= 1'b1;
    rd_chk("perr_off", 12'h01C, 32'h0220_5131);
    wr(12'h040, 32'h40);
    perr_n <= 1'b0;
    repeat (5) @(posedge pclk);
    perr_n <= 1'b1;
    flag(24);
    serr_n <= 1'b0;
    repeat (5) @(posedge pclk);
    serr_n <= 1'b1;
    flag(30);
  endtask : t_evt
  task automatic t_irq;
    wr(12'h04C, 32'h0);
    // Earlier scenarios left every interrupt status bit set
    wr(12'h048, 32'h0000_003F);
    evt <= bsc_pkg::bsc_evt_t'(4'h8);
    @(posedge pclk);
    evt <= '0;
    repeat (3) @(posedge pclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rd_chk("irq_stat", 12'h044, 32'h2);
    wr(12'h04C, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(12'h048, 32'h2);
    wr(12'h01C, 32'h0800_5030);
    repeat (2) @(posedge pclk);
    chk("irq_off", 32'h0, {31'h0, irq});
  endtask : t_irq
  task automatic t_lat;
    int hits;
    hits = 0;
    wr(12'h018, 32'h0300_0000);
    mst <= 2'b10;
    @(posedge pclk);
    mst <= 2'b00;
    repeat (4) @(negedge pclk);
    chk("early", 32'h0, {31'h0, unclaimed_timeout});
    @(negedge pclk);
    chk("expire", 32'h1, {31'h0, unclaimed_timeout});
    flag(29);
    mst <= 2'b10;
    @(posedge pclk);
    mst <= 2'b01;
    repeat (8)
    begin
      @(negedge pclk);
      hits += unclaimed_timeout;
    end
    chk("claimed", 32'h0, hits);
    @(posedge pclk);
    mst <= 2'b00;
  endtask : t_lat
  task automatic results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_win();
    t_evt();
    t_irq();
    t_lat();
    results();
  end
  initial
  begin
    #50000;
    errors++;
    results();
  end
endmodule : bsc_regs_tb
